// >>> core/tpu_pkg.sv
// Shared constants and types of the timer and PWM unit.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package tpu_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_MATCH = 7;
    localparam int NUM_CAP   = 2;
    localparam int CNT_W     = 32;
    localparam int SEL_W     = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] COUNT_RST   = 32'h0000_0000;
    localparam logic [31:0] PRESCL_RST  = 32'h0000_0000;
    localparam logic [31:0] MATCH_RST   = 32'h0000_0000;
    localparam logic [31:0] CAPTURE_RST = 32'h0000_0000;

    // ****************************************
    // Flag layout: matches low, captures above
    // ****************************************
    localparam int FLAG_CAP_POS = 7;
    localparam int NUM_FLAG     = 9;

    // ****************************************
    // Run state of the counter
    // ****************************************
    typedef enum logic [2:0] {
        TPU_HALT = 3'b001,
        TPU_RUN  = 3'b010,
        TPU_STOP = 3'b100
    } tpu_run_type;

endpackage : tpu_pkg

// >>> core/tpu_match_bank.sv
// Shadow and active match values with release latching.
// Assumes the caller raises load_in at a cycle boundary, or holds it high while values may load at once.
`timescale 1ns/100ps
module tpu_match_bank #(
    parameter int NUM = 7,
    parameter int W   = 32
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 wr_in,
    input  wire logic [2:0]           wr_sel_in,
    input  wire logic [W-1:0]         wr_data_in,
    input  wire logic [NUM-1:0]       release_in,
    input  wire logic                 load_in,
    output logic      [NUM-1:0][W-1:0] active_out,
    output logic      [NUM-1:0]       pending_out
);

    typedef struct packed {
        logic [NUM-1:0][W-1:0] shadow;
        logic [NUM-1:0][W-1:0] active;
        logic [NUM-1:0]        pending;
    } tpu_bank_type;

    tpu_bank_type st_r;
    tpu_bank_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr_in && (int'(wr_sel_in) < NUM)) begin
            st_nxt.shadow[wr_sel_in] = wr_data_in;
        end
        st_nxt.pending = st_r.pending | release_in;
        // Released values move only together, so no half-updated pulse
        if (load_in) begin
            for (int i = 0; i < NUM; i++) begin
                if (st_nxt.pending[i]) begin
                    st_nxt.active[i] = st_nxt.shadow[i];
                end
            end
            st_nxt.pending = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r.shadow  <= {NUM{tpu_pkg::MATCH_RST[W-1:0]}};
            st_r.active  <= {NUM{tpu_pkg::MATCH_RST[W-1:0]}};
            st_r.pending <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active_out  = st_r.active;
    assign pending_out = st_r.pending;

endmodule : tpu_match_bank

// >>> core/tpu_timer_pwm.sv
// Timer/counter with prescaler, seven matches, two captures and PWM.
// Assumes all inputs synchronous to clk_in; controls are plain ports.
//
// Overview of operation
// - Counter advances once per prescaled period
// - Counts clock or selected capture input edges
// - Seven match registers shared by PWM outputs
// - Match can continue, stop or reset, interrupt
// - Match zero resets count, sets PWM cycle
// - Single-edge outputs rise at cycle start
// - Double-edge: one match rises, next falls
// - Both edges anywhere inside the cycle
// - All PWM outputs share one repetition rate
// - Any count allowed for period and width
// - Released match values load at PWM cycle boundary
// - PWM off behaves as plain timer
// - Input transition latches count into capture
`timescale 1ns/100ps
module tpu_timer_pwm #(
    parameter int NUM_MATCH = tpu_pkg::NUM_MATCH,
    parameter int NUM_CAP   = tpu_pkg::NUM_CAP,
    parameter int CNT_W     = tpu_pkg::CNT_W
) (
    input  wire logic                   clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   count_enable_in,
    input  wire logic                   count_reset_in,
    input  wire logic [CNT_W-1:0]       prescale_in,
    input  wire logic                   count_src_in,
    input  wire logic                   count_cap_sel_in,
    input  wire logic                   count_rise_in,
    input  wire logic                   count_fall_in,
    input  wire logic                   match_wr_in,
    input  wire logic [2:0]             match_sel_in,
    input  wire logic [CNT_W-1:0]       match_data_in,
    input  wire logic [NUM_MATCH-1:0]   match_release_in,
    input  wire logic [NUM_MATCH-1:0]   match_int_en_in,
    input  wire logic [NUM_MATCH-1:0]   match_reset_en_in,
    input  wire logic [NUM_MATCH-1:0]   match_stop_en_in,
    input  wire logic                   pwm_enable_in,
    input  wire logic [NUM_MATCH-1:1]   pwm_out_en_in,
    input  wire logic [NUM_MATCH-1:2]   pwm_double_in,
    input  wire logic [NUM_CAP-1:0]     cap_in,
    input  wire logic [NUM_CAP-1:0]     cap_rise_en_in,
    input  wire logic [NUM_CAP-1:0]     cap_fall_en_in,
    input  wire logic [NUM_CAP-1:0]     cap_int_en_in,
    input  wire logic [tpu_pkg::NUM_FLAG-1:0] flag_clear_in,
    output logic      [CNT_W-1:0]       count_out,
    output logic      [CNT_W-1:0]       prescale_count_out,
    output logic      [NUM_CAP-1:0][CNT_W-1:0] capture_out,
    output logic      [tpu_pkg::NUM_FLAG-1:0]  flag_out,
    output logic      [NUM_MATCH-1:1]   pwm_out,
    output logic                        running_out
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        tpu_pkg::tpu_run_type                run;
        logic [CNT_W-1:0]                    tc;
        logic [CNT_W-1:0]                    pc;
        logic [NUM_CAP-1:0][CNT_W-1:0]       cap;
        logic [NUM_CAP-1:0]                  cap_prev;
        logic [tpu_pkg::NUM_FLAG-1:0]        flag;
        logic [NUM_MATCH-1:1]                pwm;
    } tpu_state_type;

    tpu_state_type st_r;
    tpu_state_type st_nxt;

    logic [NUM_MATCH-1:0][CNT_W-1:0] act_val;
    logic [NUM_MATCH-1:0]            pend;
    logic                            running;
    logic                            step;
    logic                            tick;
    logic [NUM_MATCH-1:0]            hit;
    logic                            do_reset;
    logic                            do_stop;
    logic                            load;
    logic [NUM_CAP-1:0]              cap_evt;
    logic                            src_lvl;
    logic                            src_prev;

    function automatic logic edge_hit(input logic prev, input logic cur,
                                      input logic rise, input logic fall);
        edge_hit = (rise && !prev && cur) || (fall && prev && !cur);
    endfunction : edge_hit

    // ****************************************
    // Match storage
    // ****************************************
    tpu_match_bank #(
        .NUM (NUM_MATCH),
        .W   (CNT_W)
    ) u_bank (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .wr_in       (match_wr_in),
        .wr_sel_in   (match_sel_in),
        .wr_data_in  (match_data_in),
        .release_in  (match_release_in),
        .load_in     (load),
        .active_out  (act_val),
        .pending_out (pend)
    );

    // ****************************************
    // Count events
    // ****************************************
    assign running  = (st_r.run == tpu_pkg::TPU_RUN) && !count_reset_in;
    assign src_lvl  = cap_in[count_cap_sel_in];
    assign src_prev = st_r.cap_prev[count_cap_sel_in];
    // Counter mode steps the prescaler on chosen input edges
    assign step = running && (!count_src_in ||
                  edge_hit(src_prev, src_lvl, count_rise_in, count_fall_in));
    assign tick = step && (st_r.pc == prescale_in);

    always_comb begin
        for (int i = 0; i < NUM_MATCH; i++) begin
            hit[i] = tick && (st_r.tc == act_val[i]);
        end
        for (int c = 0; c < NUM_CAP; c++) begin
            cap_evt[c] = edge_hit(st_r.cap_prev[c], cap_in[c],
                                  cap_rise_en_in[c], cap_fall_en_in[c]);
        end
    end

    assign do_reset = |(hit & match_reset_en_in)
                      || (pwm_enable_in && hit[0]);
    assign do_stop  = |(hit & match_stop_en_in);
    // Plain timer or a counter not running takes released values at once; running PWM waits for cycle end
    assign load = !pwm_enable_in || !running
                  || (hit[0] && tick);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.cap_prev = cap_in;
        case (st_r.run)
            tpu_pkg::TPU_HALT: begin
                if (count_enable_in) begin
                    st_nxt.run = tpu_pkg::TPU_RUN;
                end
            end
            tpu_pkg::TPU_RUN: begin
                if (!count_enable_in) begin
                    st_nxt.run = tpu_pkg::TPU_HALT;
                end else if (do_stop) begin
                    st_nxt.run = tpu_pkg::TPU_STOP;
                end
            end
            tpu_pkg::TPU_STOP: begin
                // Stopped stays stopped until software drops enable
                if (!count_enable_in) begin
                    st_nxt.run = tpu_pkg::TPU_HALT;
                end
            end
            default: begin
                st_nxt.run = tpu_pkg::TPU_HALT;
            end
        endcase

        if (count_reset_in) begin
            st_nxt.tc = tpu_pkg::COUNT_RST[CNT_W-1:0];
            st_nxt.pc = tpu_pkg::PRESCL_RST[CNT_W-1:0];
        end else if (step) begin
            if (tick) begin
                st_nxt.pc = tpu_pkg::PRESCL_RST[CNT_W-1:0];
                if (do_reset) begin
                    st_nxt.tc = tpu_pkg::COUNT_RST[CNT_W-1:0];
                end else if (!do_stop) begin
                    st_nxt.tc = st_r.tc + CNT_W'(1);
                end
            end else begin
                st_nxt.pc = st_r.pc + CNT_W'(1);
            end
        end

        for (int c = 0; c < NUM_CAP; c++) begin
            if (cap_evt[c]) begin
                st_nxt.cap[c] = st_r.tc;
            end
        end

        // Set is applied after clear so a coincident event survives
        st_nxt.flag = st_r.flag & ~flag_clear_in;
        st_nxt.flag[NUM_MATCH-1:0] = st_nxt.flag[NUM_MATCH-1:0]
                                     | (hit & match_int_en_in);
        st_nxt.flag[tpu_pkg::FLAG_CAP_POS +: NUM_CAP] =
            st_nxt.flag[tpu_pkg::FLAG_CAP_POS +: NUM_CAP]
            | (cap_evt & cap_int_en_in);

        // Fall wins a tie, so equal edges give a constant low output
        for (int n = 1; n < NUM_MATCH; n++) begin
            if (!pwm_enable_in || !pwm_out_en_in[n]) begin
                st_nxt.pwm[n] = 1'b0;
            end else if (hit[n]) begin
                st_nxt.pwm[n] = 1'b0;
            end else if ((n >= 2) && pwm_double_in[n]) begin
                if (hit[n-1]) begin
                    st_nxt.pwm[n] = 1'b1;
                end
            end else if (hit[0]) begin
                st_nxt.pwm[n] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            st_r.run      <= tpu_pkg::TPU_HALT;
            st_r.tc       <= tpu_pkg::COUNT_RST[CNT_W-1:0];
            st_r.pc       <= tpu_pkg::PRESCL_RST[CNT_W-1:0];
            st_r.cap      <= {NUM_CAP{tpu_pkg::CAPTURE_RST[CNT_W-1:0]}};
            st_r.cap_prev <= '0;
            st_r.flag     <= '0;
            st_r.pwm      <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_out          = st_r.tc;
    assign prescale_count_out = st_r.pc;
    assign capture_out        = st_r.cap;
    assign flag_out           = st_r.flag;
    assign pwm_out            = st_r.pwm;
    // One-hot code: bit 1 alone marks the run state
    assign running_out        = st_r.run[1];

    // ****************************************
    // Checks
    // ****************************************
    a_count_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        tick && !do_reset && !do_stop |=> st_r.tc == $past(st_r.tc) + 1)
        else $error("count did not advance on prescaled tick");
    a_count_src: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        count_src_in && !step && !count_reset_in
        |=> st_r.pc == $past(st_r.pc) && st_r.tc == $past(st_r.tc))
        else $error("counter moved without a source edge");
    a_cycle_wrap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pwm_enable_in && hit[0] && !count_reset_in |=> st_r.tc == '0)
        else $error("cycle match did not clear count");
    a_stop_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        do_stop && count_enable_in && !count_reset_in
        ##1 count_enable_in && !count_reset_in
        |=> st_r.tc == $past(st_r.tc) && !running_out)
        else $error("stop on match did not halt counter");
    a_single_rise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pwm_enable_in && pwm_out_en_in[1] && hit[0] && !hit[1]
        |=> pwm_out[1])
        else $error("single edge output missed cycle start");
    a_single_fall: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pwm_enable_in && hit[1] |=> !pwm_out[1])
        else $error("single edge output missed its fall");
    a_double_edge: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pwm_enable_in && pwm_out_en_in[3] && pwm_double_in[3]
        && hit[2] && !hit[3] |=> pwm_out[3])
        else $error("double edge output missed its rise");
    a_plain_timer: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !pwm_enable_in |=> pwm_out == '0)
        else $error("PWM output active with PWM disabled");
    a_release_sync: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pwm_enable_in && running && !hit[0]
        |=> act_val == $past(act_val))
        else $error("match value changed inside a PWM cycle");
    a_capture_take: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cap_evt[0] |=> capture_out[0] == $past(st_r.tc))
        else $error("capture did not latch the count");
    a_flag_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        flag_out[0] && !flag_clear_in[0] ##1 !flag_clear_in[0]
        |-> flag_out[0])
        else $error("pending flag cleared without a write");
    a_halt_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        st_r.run == tpu_pkg::TPU_HALT && !count_enable_in && !count_reset_in
        |=> st_r.tc == $past(st_r.tc) && st_r.pc == $past(st_r.pc))
        else $error("halted counter moved");

endmodule : tpu_timer_pwm

// >>> tb/tpu_load_model.sv
// Passive load on the PWM pins: measures pulse width and period.
// Assumes pwm lines change only just after rising edges of clk_in.
`timescale 1ns/100ps
module tpu_load_model (
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [6:1]       pwm_in,
    output logic      [6:1][15:0] width_out,
    output logic      [6:1][15:0] period_out
);
    // ****************************************
    // Edge timing per output
    // ****************************************
    logic [6:1]       last_r;
    logic [6:1][15:0] since_r;
    logic [6:1][15:0] run_r;

    // A driver stage draws no handshake, so the model only listens
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            last_r     <= '0;
            since_r    <= '0;
            run_r      <= '0;
            width_out  <= '0;
            period_out <= '0;
        end else begin
            for (int i = 1; i <= 6; i++) begin
                if (pwm_in[i] && !last_r[i]) begin
                    period_out[i] <= since_r[i];
                    since_r[i]    <= 16'h0001;
                    run_r[i]      <= 16'h0001;
                end else begin
                    since_r[i] <= since_r[i] + 16'h0001;
                    if (pwm_in[i]) begin
                        run_r[i] <= run_r[i] + 16'h0001;
                    end
                end
                if (!pwm_in[i] && last_r[i]) begin
                    width_out[i] <= run_r[i];
                end
                last_r[i] <= pwm_in[i];
            end
        end
    end
endmodule : tpu_load_model

// >>> tb/tpu_timer_pwm_tb.sv
// Self-checking bench for the timer and PWM unit.
// Assumes the load model is compiled before this file.
`timescale 1ns/100ps
module tpu_timer_pwm_tb;
    logic             clk_in;
    logic             reset_n_in;
    logic             cnt_en, cnt_rst, cnt_src, cnt_sel, cnt_rise, cnt_fall;
    logic [31:0]      prescale, m_data, c0;
    logic             m_wr, pwm_en;
    logic [2:0]       m_sel;
    logic [6:0]       m_rel, m_int, m_rst, m_stop;
    logic [6:1]       out_en, pwm;
    logic [6:2]       dbl;
    logic [1:0]       cap, cap_rise, cap_fall, cap_int;
    logic [8:0]       clr, flag;
    logic [31:0]      count, pcount;
    logic [1:0][31:0] capture;
    logic             running;
    logic [6:1][15:0] width, period;
    logic [31:0]      mv [0:5] = '{32'h9, 32'h3, 32'h2, 32'h7, 32'h6, 32'h1};
    logic [15:0]      ew [1:6] = '{16'h4, 16'h3, 16'h5, 16'h7, 16'h5, 16'h0};
    int               bad_count = 0;
    int               total_checks = 0;
    int               cycles = 0;

    tpu_timer_pwm dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .count_enable_in(cnt_en), .count_reset_in(cnt_rst),
        .prescale_in(prescale), .count_src_in(cnt_src),
        .count_cap_sel_in(cnt_sel), .count_rise_in(cnt_rise),
        .count_fall_in(cnt_fall), .match_wr_in(m_wr),
        .match_sel_in(m_sel), .match_data_in(m_data),
        .match_release_in(m_rel), .match_int_en_in(m_int),
        .match_reset_en_in(m_rst), .match_stop_en_in(m_stop),
        .pwm_enable_in(pwm_en), .pwm_out_en_in(out_en),
        .pwm_double_in(dbl), .cap_in(cap), .cap_rise_en_in(cap_rise),
        .cap_fall_en_in(cap_fall), .cap_int_en_in(cap_int),
        .flag_clear_in(clr), .count_out(count),
        .prescale_count_out(pcount), .capture_out(capture),
        .flag_out(flag), .pwm_out(pwm), .running_out(running));

    tpu_load_model load (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .pwm_in(pwm),
        .width_out(width), .period_out(period));

    // ****************************************
    // Clock, watchdog and shared tasks
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Whole run is well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            test_done();
        end
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_cyc

    task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_value

    task automatic set_match(input logic [2:0] sel, input logic [31:0] data,
                             input logic wr, input logic rel);
        m_wr   = wr;
        m_sel  = sel;
        m_data = data;
        m_rel[sel] = rel;
        wait_cyc(1);
        m_wr  = 1'b0;
        m_rel = 7'h00;
        // Idle edge so back-to-back calls never retoggle the strobe
        wait_cyc(1);
    endtask : set_match

    task automatic pulse_cap(input int idx);
        cap[idx] = 1'b1;
        wait_cyc(2);
        cap[idx] = 1'b0;
        wait_cyc(2);
    endtask : pulse_cap

    task automatic test_done();
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {reset_n_in, cnt_en, cnt_rst, cnt_src, cnt_sel, cnt_rise} = 6'h00;
        {cnt_fall, m_wr, pwm_en, m_sel, m_data} = '0;
        {m_rel, m_int, m_rst, m_stop, out_en, dbl} = '0;
        {cap, cap_rise, cap_fall, cap_int, clr} = '0;
        prescale = 32'h0000_0002;
        wait_cyc(6);
        reset_n_in = 1'b1;
        check_value(count, 32'h0);
        check_value(pcount, 32'h0);
        check_value(capture[0] | capture[1], 32'h0);
        check_value({16'h0, flag, pwm, running}, 32'h0);
        set_match(3'h1, 32'h5, 1'b1, 1'b1);
        m_stop = 7'h02;
        m_int  = 7'h02;
        wait_cyc(4);
        check_value(count, 32'h0);
        cnt_en = 1'b1;
        wait_cyc(3);
        c0 = count;
        wait_cyc(9);
        check_value(count, c0 + 32'h3);
        check_value(pcount, 32'h2);
        wait_cyc(30);
        check_value({31'h0, running}, 32'h0);
        check_value(count, 32'h5);
        cap_rise = 2'b10;
        cap_int  = 2'b10;
        pulse_cap(1);
        check_value(capture[1], 32'h5);
        wait_cyc(5);
        check_value({23'h0, flag}, 32'h102);
        clr = 9'h002;
        wait_cyc(1);
        clr = 9'h000;
        wait_cyc(1);
        check_value({23'h0, flag}, 32'h100);
        // Counter mode: edges of capture input 0 drive the count
        {cnt_en, cnt_rst, m_stop, m_int} = {2'b01, 14'h0};
        {prescale, cnt_src, cnt_rise, cnt_fall} = {32'h0, 3'b111};
        {cap_rise, cap_fall} = 4'b1101;
        wait_cyc(2);
        {cnt_en, cnt_rst} = 2'b10;
        wait_cyc(2);
        repeat (4) pulse_cap(0);
        wait_cyc(3);
        check_value(count, 32'h8);
        check_value(capture[0], 32'h7);
        // PWM: three single, two double edge, one constant low
        {cnt_en, cnt_rst, cnt_src, pwm_en} = 4'b0101;
        out_en = 6'h1F;
        dbl    = 5'b01010;
        for (int i = 0; i < 6; i++) begin
            set_match(3'(i), mv[i], 1'b1, 1'b1);
        end
        {cnt_en, cnt_rst} = 2'b10;
        wait_cyc(45);
        for (int i = 1; i <= 6; i++) begin
            check_value({16'h0, width[i]}, {16'h0, ew[i]});
        end
        for (int i = 1; i <= 5; i++) begin
            check_value({16'h0, period[i]}, 32'hA);
        end
        set_match(3'h1, 32'h6, 1'b1, 1'b0);
        wait_cyc(30);
        check_value({16'h0, width[1]}, 32'h4);
        set_match(3'h1, 32'h6, 1'b0, 1'b1);
        wait_cyc(30);
        check_value({16'h0, width[1]}, 32'h7);
        // Plain timer: match zero resets only by its own action
        clr = 9'h1FF;
        wait_cyc(1);
        clr    = 9'h000;
        pwm_en = 1'b0;
        m_rst  = 7'h01;
        m_int  = 7'h01;
        wait_cyc(30);
        check_value({26'h0, pwm}, 32'h0);
        check_value({23'h0, flag}, 32'h1);
        check_value({31'h0, count <= 32'h9}, 32'h1);
        test_done();
    end
endmodule : tpu_timer_pwm_tb
